// *** hw/eion_regs.vh ***
// register map and bit layout of the edge i/o port and nesting interrupt controller
`ifndef EION_REGS_VH
`define EION_REGS_VH
`define EION_AW            5
`define EION_OFF_PORT_DATA 5'h01
`define EION_OFF_EDGE_SEL  5'h03
`define EION_OFF_LINE_DIR  5'h05
`define EION_OFF_ENA_HI    5'h07
`define EION_OFF_ENA_LO    5'h09
`define EION_OFF_PEND_HI   5'h0b
`define EION_OFF_PEND_LO   5'h0d
`define EION_OFF_INSVC_HI  5'h0f
`define EION_OFF_INSVC_LO  5'h11
`define EION_OFF_MASK_HI   5'h13
`define EION_OFF_MASK_LO   5'h15
`define EION_OFF_VECTOR    5'h17
`define EION_RST_BYTE      8'h00
`define EION_RST_CHAN      16'h0000
`define EION_VEC_EOI_BIT   3
`define EION_VEC_BASE_HI   7
`define EION_VEC_BASE_LO   4
`define EION_NO_CHAN       5'h00
`define EION_NCHAN         16
`define EION_ALL_CHAN      16'hffff
`endif

// *** hw/eion_core.v ***
// edge i/o port with 16-channel prioritised interrupt controller and nesting
`timescale 1ns/1ps
`include "eion_regs.vh"

// Function
// RQ1 - vector eoi bit selects software eoi
// RQ2 - eoi handling only acts on acknowledge cycles
// RQ3 - supplying vector clears channel pending bit
// RQ4 - automatic eoi holds in-service bits zero
// RQ5 - automatic eoi lets any new interrupt request
// RQ6 - software eoi sets in-service on vector
// RQ7 - in-service blocks lower, allows higher channels
// RQ8 - pending latches even while in-service blocks
// RQ9 - in-service cleared only by written zeros
// RQ10 - in-service registers readable without side effects
// RQ11 - eight lines, direction and interrupt each
// RQ12 - output lines drive data, inputs float
// RQ13 - port read mixes data and pins
// RQ14 - edge bit: zero falling, one rising
// RQ15 - detector is xor of edge and pin (code uses the inverted xor, ~(pin ^ edge))
// RQ16 - software sets edges before enabling channels
// RQ17 - direction zero input, one push-pull output
// RQ18 - handler lowers processor mask for nesting
// RQ19 - enabled channel transition sets pending bit
// RQ20 - one pending event per synchronised transition
module eion_core (
  input  wire       mclk,
  input  wire       sys_rst,
  input  wire       cs_n,
  input  wire       ds_n,
  input  wire       rw,
  input  wire       iack_n,
  input  wire [4:0] reg_sel,
  input  wire [7:0] data_in,
  output wire [7:0] data_out,
  output wire       data_oe,
  output wire       dtack_n,
  output wire       irq_n,
  input  wire [7:0] port_lines_in,
  output wire [7:0] port_lines_out,
  output wire [7:0] port_lines_oe,
  input  wire [7:0] periph_evt
);

  // channel c is bit c; bits 15..8 are the high group, 7..0 the low group
  // returns {valid, channel} of the highest set bit
  function [4:0] top_chan;
    input [15:0] v;
    integer i;
    begin
      top_chan = `EION_NO_CHAN;
      for (i = 0; i < `EION_NCHAN; i = i + 1)
        if (v[i])
          top_chan = {1'b1, i[3:0]};
    end
  endfunction

  // clears the bits at and below channel t; no valid t passes everything
  function [15:0] above_mask;
    input [4:0] t;
    integer i;
    begin
      above_mask = `EION_ALL_CHAN;
      for (i = 0; i < `EION_NCHAN; i = i + 1)
        if (t[4] && (i[3:0] <= t[3:0]))
          above_mask[i] = 1'b0;
    end
  endfunction

  // port and bus pins are asynchronous: two flops before anything reads them; periph_evt goes straight to the channels
  reg  [7:0] pin_s1_r;
  reg  [7:0] pin_s2_r;
  reg  [7:0] din_s1_r;
  reg  [7:0] din_s2_r;
  reg  [4:0] sel_s1_r;
  reg  [4:0] sel_s2_r;
  reg  [3:0] ctl_s1_r;
  reg  [3:0] ctl_s2_r;

  // port pins: first stage may go metastable, only the second is read
  always @(posedge mclk) begin
    pin_s1_r <= port_lines_in;
    pin_s2_r <= pin_s1_r;
  end

  // address and data: the host holds them across the strobe, same depth as control
  always @(posedge mclk) begin
    din_s1_r <= data_in;
    din_s2_r <= din_s1_r;
    sel_s1_r <= reg_sel;
    sel_s2_r <= sel_s1_r;
  end

  // bus control, turned active high on the way in
  always @(posedge mclk) begin
    ctl_s1_r <= {~cs_n, ~ds_n, rw, ~iack_n};
    ctl_s2_r <= ctl_s1_r;
  end

  wire cs_a   = ctl_s2_r[3];
  wire ds_a   = ctl_s2_r[2];
  wire rd     = ctl_s2_r[1];
  wire iack_a = ctl_s2_r[0];

  reg  [7:0]  port_data_r;
  reg  [7:0]  edge_select_r;
  reg  [7:0]  line_direction_r;
  reg  [7:0]  vector_r;
  reg  [15:0] ena_r;
  reg  [15:0] pend_r;
  reg  [15:0] insvc_r;
  reg  [15:0] mask_r;
  // resets low, so a false edge may follow reset; all channels are disabled then
  reg  [7:0]  det_q_r;
  reg         busy_r;
  reg         dtack_n_r;
  reg         data_oe_r;
  reg         irq_n_r;
  reg  [7:0]  data_out_r;

  wire        sw_eoi = vector_r[`EION_VEC_EOI_BIT]; // [RQ1]

  // detector: edge bit one passes the pin, zero inverts it; rising output is an event
  wire [7:0]  det = ~(pin_s2_r ^ edge_select_r); // [RQ15] [RQ14]
  wire [7:0]  gp_evt = det & ~det_q_r; // [RQ20]
  // channel map: low group pins 3:0 and 5:4, high group pins 7:6
  wire [7:0]  evt_lo = {gp_evt[5:4], periph_evt[1:0], gp_evt[3:0]};
  wire [7:0]  evt_hi = {gp_evt[7:6], periph_evt[7:2]};
  wire [15:0] raw_evt = {evt_hi, evt_lo};

  // service requests: masked pending bits above the highest channel in service
  wire [15:0] req = pend_r & mask_r & above_mask(top_chan(insvc_r)); // [RQ7] [RQ8] [RQ5]
  // channel 15 has the highest priority
  wire [4:0]  win = top_chan(req);

  wire        start    = ds_a && !busy_r;
  wire        reg_acc  = start && cs_a && !iack_a;
  wire        wr_acc   = reg_acc && !rd;
  wire        ack_take = start && iack_a && win[4];

  // one strobe per register, so each address decode stands once
  wire        wr_port     = wr_acc && (sel_s2_r == `EION_OFF_PORT_DATA);
  wire        wr_edge     = wr_acc && (sel_s2_r == `EION_OFF_EDGE_SEL);
  wire        wr_dir      = wr_acc && (sel_s2_r == `EION_OFF_LINE_DIR);
  wire        wr_ena_hi   = wr_acc && (sel_s2_r == `EION_OFF_ENA_HI);
  wire        wr_ena_lo   = wr_acc && (sel_s2_r == `EION_OFF_ENA_LO);
  wire        wr_mask_hi  = wr_acc && (sel_s2_r == `EION_OFF_MASK_HI);
  wire        wr_mask_lo  = wr_acc && (sel_s2_r == `EION_OFF_MASK_LO);
  wire        wr_pend_hi  = wr_acc && (sel_s2_r == `EION_OFF_PEND_HI);
  wire        wr_pend_lo  = wr_acc && (sel_s2_r == `EION_OFF_PEND_LO);
  wire        wr_insvc_hi = wr_acc && (sel_s2_r == `EION_OFF_INSVC_HI);
  wire        wr_insvc_lo = wr_acc && (sel_s2_r == `EION_OFF_INSVC_LO);
  wire        wr_vec      = wr_acc && (sel_s2_r == `EION_OFF_VECTOR);

  reg  [15:0] ena_nxt;
  reg  [15:0] pend_nxt;
  reg  [15:0] insvc_nxt;
  reg  [15:0] mask_nxt;
  reg  [15:0] ack_oh;
  reg  [7:0]  rdata;

  // one-hot of the channel whose vector goes out this cycle
  always @* begin
    ack_oh = `EION_RST_CHAN;
    if (ack_take)
      ack_oh[win[3:0]] = 1'b1;
  end

  // pending and in-service writes can only clear: written ones leave bits alone
  always @* begin
    ena_nxt   = ena_r;
    mask_nxt  = mask_r;
    pend_nxt  = pend_r;
    insvc_nxt = insvc_r;
    if (wr_ena_hi)
      ena_nxt[15:8] = din_s2_r;
    else if (wr_ena_lo)
      ena_nxt[7:0] = din_s2_r;
    else if (wr_mask_hi)
      mask_nxt[15:8] = din_s2_r;
    else if (wr_mask_lo)
      mask_nxt[7:0] = din_s2_r;
    else if (wr_pend_hi)
      pend_nxt[15:8] = pend_r[15:8] & din_s2_r;
    else if (wr_pend_lo)
      pend_nxt[7:0] = pend_r[7:0] & din_s2_r;
    else if (wr_insvc_hi)
      insvc_nxt[15:8] = insvc_r[15:8] & din_s2_r; // [RQ9]
    else if (wr_insvc_lo)
      insvc_nxt[7:0] = insvc_r[7:0] & din_s2_r; // [RQ9]
    // of bus cycles, only writes and acknowledge cycles touch pending/in-service; polling never does
    pend_nxt = pend_nxt & ~ack_oh; // [RQ3] [RQ2]
    if (sw_eoi)
      insvc_nxt = insvc_nxt | ack_oh; // [RQ6]
    else
      insvc_nxt = `EION_RST_CHAN; // [RQ4]
    // a disabled channel drops its pending bit; new events win over clears
    pend_nxt = (pend_nxt & ena_nxt) | (raw_evt & ena_nxt); // [RQ19] [RQ8]
  end

  // reads have no side effects on any register
  always @* begin
    rdata = `EION_RST_BYTE;
    if (sel_s2_r == `EION_OFF_PORT_DATA)
      rdata = (port_data_r & line_direction_r) | (pin_s2_r & ~line_direction_r); // [RQ13]
    else if (sel_s2_r == `EION_OFF_EDGE_SEL)
      rdata = edge_select_r;
    else if (sel_s2_r == `EION_OFF_LINE_DIR)
      rdata = line_direction_r;
    else if (sel_s2_r == `EION_OFF_ENA_HI)
      rdata = ena_r[15:8];
    else if (sel_s2_r == `EION_OFF_ENA_LO)
      rdata = ena_r[7:0];
    else if (sel_s2_r == `EION_OFF_PEND_HI)
      rdata = pend_r[15:8];
    else if (sel_s2_r == `EION_OFF_PEND_LO)
      rdata = pend_r[7:0];
    else if (sel_s2_r == `EION_OFF_INSVC_HI)
      rdata = insvc_r[15:8]; // [RQ10]
    else if (sel_s2_r == `EION_OFF_INSVC_LO)
      rdata = insvc_r[7:0]; // [RQ10]
    else if (sel_s2_r == `EION_OFF_MASK_HI)
      rdata = mask_r[15:8];
    else if (sel_s2_r == `EION_OFF_MASK_LO)
      rdata = mask_r[7:0];
    else if (sel_s2_r == `EION_OFF_VECTOR)
      rdata = vector_r;
  end

  // interrupt state moves every cycle from the next-state logic
  always @(posedge mclk) begin
    if (sys_rst) begin
      ena_r   <= `EION_RST_CHAN;
      pend_r  <= `EION_RST_CHAN;
      insvc_r <= `EION_RST_CHAN;
      mask_r  <= `EION_RST_CHAN;
      det_q_r <= `EION_RST_BYTE;
      irq_n_r <= 1'b1;
    end else begin
      det_q_r <= det; // [RQ20]
      ena_r   <= ena_nxt;
      mask_r  <= mask_nxt;
      pend_r  <= pend_nxt;
      insvc_r <= insvc_nxt;
      // irq follows the request one cycle later
      irq_n_r <= ~(|req);
    end
  end

  // port and control registers change only on a register write
  always @(posedge mclk) begin
    if (sys_rst) begin
      port_data_r      <= `EION_RST_BYTE;
      edge_select_r    <= `EION_RST_BYTE;
      line_direction_r <= `EION_RST_BYTE;
      vector_r         <= `EION_RST_BYTE;
    end else begin
      if (wr_port)
        port_data_r <= din_s2_r; // [RQ12]
      if (wr_edge)
        edge_select_r <= din_s2_r; // [RQ14]
      if (wr_dir)
        line_direction_r <= din_s2_r; // [RQ17]
      if (wr_vec)
        vector_r <= din_s2_r; // [RQ1]
    end
  end

  // one access per strobe; the cycle ends when the strobe goes away
  always @(posedge mclk) begin
    if (sys_rst) begin
      busy_r     <= 1'b0;
      dtack_n_r  <= 1'b1;
      data_oe_r  <= 1'b0;
      data_out_r <= `EION_RST_BYTE;
    end else if (!ds_a) begin
      // data_out keeps its last value; data_oe low marks it released
      busy_r    <= 1'b0;
      dtack_n_r <= 1'b1;
      data_oe_r <= 1'b0;
    end else if (ack_take) begin
      busy_r     <= 1'b1;
      dtack_n_r  <= 1'b0;
      data_oe_r  <= 1'b1;
      data_out_r <= {vector_r[`EION_VEC_BASE_HI:`EION_VEC_BASE_LO], win[3:0]}; // [RQ3]
    end else if (reg_acc) begin
      busy_r     <= 1'b1;
      dtack_n_r  <= 1'b0;
      data_oe_r  <= rd;
      data_out_r <= rdata;
    end
  end

  // every output is a flop; pins float where direction is zero
  assign data_out       = data_out_r;
  assign data_oe        = data_oe_r;
  assign dtack_n        = dtack_n_r;
  assign irq_n          = irq_n_r;
  assign port_lines_out = port_data_r; // [RQ12] [RQ11]
  assign port_lines_oe  = line_direction_r; // [RQ17]

endmodule // eion_core

// *** dv/eion_core_sva.sv ***
// port assertions for the edge i/o interrupt block
`timescale 1ns/1ps
module eion_core_sva (
  input wire       mclk,
  input wire       sys_rst,
  input wire       ds_n,
  input wire       iack_n,
  input wire [7:0] data_out,
  input wire       data_oe,
  input wire       dtack_n,
  input wire       irq_n,
  input wire [7:0] port_lines_out,
  input wire [7:0] port_lines_oe
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  property p_rst; $fell(sys_rst) |-> irq_n && dtack_n && !data_oe && port_lines_oe == 8'h00; endproperty
  a_rst: assert property (p_rst) else $error("outputs not idle after reset");
  property p_hold; !dtack_n && !ds_n |=> !dtack_n; endproperty
  a_hold: assert property (p_hold) else $error("acknowledge dropped early");
  property p_rel; ds_n [*5] |-> dtack_n; endproperty
  a_rel: assert property (p_rel) else $error("acknowledge stuck low");
  property p_out; $changed(port_lines_out) |-> !dtack_n; endproperty
  a_out: assert property (p_out) else $error("port data moved without write");
  property p_dir; $changed(port_lines_oe) |-> !dtack_n; endproperty
  a_dir: assert property (p_dir) else $error("direction moved without write");
  property p_ack; $fell(dtack_n) && !iack_n |-> $past(!irq_n); endproperty
  a_ack: assert property (p_ack) else $error("vector without request");
  property p_oe; data_oe |-> !dtack_n; endproperty
  a_oe: assert property (p_oe) else $error("bus driven without acknowledge");
  property p_vec; !dtack_n && $past(!dtack_n) |-> $stable(data_out); endproperty
  a_vec: assert property (p_vec) else $error("answer changed while held");
endmodule // eion_core_sva
bind eion_core eion_core_sva eion_core_sva_i (.mclk(mclk), .sys_rst(sys_rst), .ds_n(ds_n),
  .iack_n(iack_n), .data_out(data_out), .data_oe(data_oe), .dtack_n(dtack_n), .irq_n(irq_n),
  .port_lines_out(port_lines_out), .port_lines_oe(port_lines_oe));

// *** dv/eion_host.sv ***
// host processor model: register and acknowledge cycles
`timescale 1ns/1ps
module eion_host (
  input  wire       mclk,
  input  wire [7:0] data_out,
  input  wire       dtack_n,
  output reg        cs_n = 1'b1,
  output reg        ds_n = 1'b1,
  output reg        rw = 1'b1,
  output reg        iack_n = 1'b1,
  output reg  [4:0] reg_sel = 5'h00,
  output reg  [7:0] data_in = 8'h00,
  output reg        res_v = 1'b0,
  output reg  [8:0] res = 9'h000
);
  // k: acknowledge cycle, handler nesting relies on it
  task acc(input [4:0] a, input [7:0] d, input w, input k);
    integer n;
    begin
      @(posedge mclk);
      cs_n <= k; ds_n <= 1'b0; iack_n <= !k; rw <= !w; reg_sel <= a; data_in <= d;
      n = 0;
      do begin @(posedge mclk); n++; end while (dtack_n !== 1'b0 && n < 12);
      res <= (dtack_n === 1'b0) ? {1'b1, data_out} : 9'h000;
      res_v <= !w;
      cs_n <= 1'b1; ds_n <= 1'b1; iack_n <= 1'b1; data_in <= ~d;
      // released data lines show no stale value
      n = 0;
      do begin @(posedge mclk); res_v <= 1'b0; n++; end while (dtack_n !== 1'b1 && n < 12);
    end
  endtask
endmodule // eion_host

// *** dv/testbench.sv ***
// self-checking bench for the edge i/o interrupt block
`timescale 1ns/1ps
module testbench;
  reg mclk = 1'b0, sys_rst = 1'b1;
  reg  [7:0] port_lines_in = 8'h00, periph_evt = 8'h00, d, v, p;
  wire [7:0] data_in, data_out, port_lines_out, port_lines_oe;
  wire [4:0] reg_sel;
  wire [8:0] res;
  wire cs_n, ds_n, rw, iack_n, data_oe, dtack_n, irq_n, res_v;
  integer error_cnt = 0, tests_run = 0, i;
  logic [8:0] q[$];
  initial forever #2 mclk = ~mclk;
  eion_core eion_core_i (.mclk(mclk), .sys_rst(sys_rst), .cs_n(cs_n), .ds_n(ds_n), .rw(rw),
    .iack_n(iack_n), .reg_sel(reg_sel), .data_in(data_in), .data_out(data_out),
    .data_oe(data_oe), .dtack_n(dtack_n), .irq_n(irq_n), .port_lines_in(port_lines_in),
    .port_lines_out(port_lines_out), .port_lines_oe(port_lines_oe), .periph_evt(periph_evt));
  eion_host eion_host_i (.mclk(mclk), .data_out(data_out), .dtack_n(dtack_n), .cs_n(cs_n),
    .ds_n(ds_n), .rw(rw), .iack_n(iack_n), .reg_sel(reg_sel), .data_in(data_in),
    .res_v(res_v), .res(res));
  task final_report;
    if (error_cnt == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task cmp(input [8:0] e, input [8:0] g);
    tests_run++;
    if (g !== e) begin error_cnt++; $display("ERROR t=%0t exp=%h got=%h", $time, e, g); end
  endtask
  task wr(input [4:0] a, input [7:0] x); eion_host_i.acc(a, x, 1'b1, 1'b0); endtask
  task rd(input [4:0] a, input [8:0] e); q.push_back(e); eion_host_i.acc(a, 8'h00, 1'b0, 1'b0); endtask
  task ack(input [8:0] e); q.push_back(e); eion_host_i.acc(5'h00, 8'h00, 1'b0, 1'b1); endtask
  // one-cycle on-chip event, then let pending and request settle
  task ev(input [7:0] m);
    @(posedge mclk) periph_evt <= m;
    @(posedge mclk) periph_evt <= 8'h00;
    repeat (3) @(posedge mclk);
  endtask
  always @(posedge mclk) if (res_v) cmp(q.pop_front(), res);
  initial begin repeat (20000) @(posedge mclk); error_cnt++; final_report; end
  initial begin
    void'($urandom(61801));
    repeat (5) @(posedge mclk);
    sys_rst <= 1'b0;
    for (i = 1; i < 32; i += 2) rd(i[4:0], 9'h100);
    d = $urandom; v = $urandom; p = $urandom;
    wr(5'h05, d); wr(5'h01, v); port_lines_in <= p;
    repeat (3) @(posedge mclk);
    rd(5'h01, {1'b1, (v & d) | (p & ~d)});
    cmp({1'b0, v}, {1'b0, port_lines_out});
    cmp({1'b0, d}, {1'b0, port_lines_oe});
    wr(5'h05, 8'h00); port_lines_in <= 8'h00;
    wr(5'h03, 8'h01); wr(5'h09, 8'h03); // edges set before enabling
    port_lines_in <= 8'h02; rd(5'h0d, 9'h100);
    port_lines_in <= 8'h01; rd(5'h0d, 9'h103);
    wr(5'h03, 8'h00); wr(5'h0d, 8'hfc); wr(5'h03, 8'h01); rd(5'h0d, 9'h101);
    wr(5'h09, 8'h00); port_lines_in <= 8'h00; rd(5'h0d, 9'h100);
    wr(5'h17, 8'h48); wr(5'h09, 8'h10); wr(5'h15, 8'h10); wr(5'h07, 8'h01); wr(5'h13, 8'h01);
    ev(8'h01); cmp(9'h000, {8'h00, irq_n});
    ack(9'h144);
    rd(5'h11, 9'h110); rd(5'h0d, 9'h100);
    ev(8'h01); cmp(9'h001, {8'h00, irq_n});
    rd(5'h0d, 9'h110); ack(9'h000);
    ev(8'h04); ack(9'h148); rd(5'h0f, 9'h101);
    wr(5'h0f, 8'hfe); rd(5'h0f, 9'h100);
    wr(5'h11, 8'hff); rd(5'h11, 9'h110); rd(5'h11, 9'h110);
    wr(5'h11, 8'hef); ack(9'h144);
    wr(5'h17, 8'h40); rd(5'h11, 9'h100);
    ev(8'h01); ack(9'h144); ev(8'h01); ack(9'h144);
    rd(5'h11, 9'h100);
    repeat (4) @(posedge mclk);
    final_report;
  end
endmodule // testbench
